// [src/ocrb_pkg.sv]
/*
  Package for the output configuration register bank: offsets, field layout, reset values, timing constants.
  Assumes an 8-bit address and 8-bit data register port on a single 125 MHz clock.
*/
package ocrb_pkg;
  // Channel count and address width
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 8;
  // Register offsets
  localparam logic [7:0] OFF_CHAN_INDEX = 8'h05;
  localparam logic [7:0] OFF_OUTPUT_MODE_FORMAT = 8'h14;
  localparam logic [7:0] OFF_OUTPUT_DRIVE_ADJUST = 8'h15;
  localparam logic [7:0] OFF_OUTPUT_CLOCK_PHASE = 8'h16;
  localparam logic [7:0] OFF_OUTPUT_CLOCK_DELAY = 8'h17;
  localparam logic [7:0] OFF_REFERENCE_FULLSCALE_SELECT = 8'h18;
  localparam logic [7:0] OFF_SELFTEST_SIGNATURE_LOW = 8'h24;
  localparam logic [7:0] OFF_SELFTEST_SIGNATURE_HIGH = 8'h25;
  // Reset values
  localparam logic [7:0] RST_CHAN_INDEX = 8'h0f;
  localparam logic [7:0] RST_OUTPUT_MODE_FORMAT = 8'h00;
  localparam logic [7:0] RST_OUTPUT_DRIVE_ADJUST = 8'h01;
  localparam logic [7:0] RST_OUTPUT_CLOCK_PHASE = 8'h00;
  localparam logic [7:0] RST_OUTPUT_CLOCK_DELAY = 8'h00;
  localparam logic [7:0] RST_REFERENCE_FULLSCALE_SELECT = 8'h00;
  // Writable bit masks; open bits read as zero
  localparam logic [7:0] MASK_CHAN_INDEX = 8'h0f;
  localparam logic [7:0] MASK_OUTPUT_MODE_FORMAT = 8'h17;
  localparam logic [7:0] MASK_OUTPUT_DRIVE_ADJUST = 8'h0f;
  localparam logic [7:0] MASK_OUTPUT_CLOCK_PHASE = 8'h80;
  localparam logic [7:0] MASK_OUTPUT_CLOCK_DELAY = 8'h9f;
  localparam logic [7:0] MASK_REFERENCE_FULLSCALE_SELECT = 8'h1f;
  // Field positions
  localparam int POS_OUT_DISABLE = 4;
  localparam int POS_OUT_INVERT = 2;
  localparam int POS_FORMAT_LO = 0;
  localparam int POS_DRIVE_LO = 0;
  localparam int POS_CLK_INVERT = 7;
  localparam int POS_DELAY_EN = 7;
  localparam int POS_DELAY_LO = 0;
  // Drive and delay steps
  localparam int DRIVE_W = 4;
  localparam int DELAY_W = 5;
  localparam int DELAY_STEP_PS = 100;
  localparam int DELAY_OUT_W = 12;
  // Drive current in microamps per code; codes above 0111 stay at the lowest level
  localparam logic [11:0] DRIVE_UA [8] = '{12'd3720, 12'd3500, 12'd3300, 12'd2960,
                                           12'd2820, 12'd2570, 12'd2270, 12'd2000};
  localparam logic [11:0] DRIVE_UA_MIN = 12'd2000;
endpackage

// [src/ocrb_channel.sv]
/*
  One channel's local configuration: stores the per-channel fields and decodes drive and delay.
  Assumes the parent passes the raw address through and gates the write with this channel's select bit; offsets are decoded here.
*/
`timescale 1ns/100ps
module ocrb_channel (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Write port
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Stored registers
  output logic [7:0] mode_reg,
  output logic [7:0] drive_reg,
  output logic [7:0] phase_reg,
  output logic [7:0] delay_reg,
  // Decoded values
  output logic [11:0] drive_ua,
  output logic [11:0] delay_ps
);
  logic [7:0] mode_next, drive_next, phase_next, delay_next;

  // Next values: only matching offset under write is changed
  always_comb begin
    mode_next = mode_reg;
    drive_next = drive_reg;
    phase_next = phase_reg;
    delay_next = delay_reg;
    if (wr_en) begin
      unique case (wr_addr)
        ocrb_pkg::OFF_OUTPUT_MODE_FORMAT: mode_next = wr_data & ocrb_pkg::MASK_OUTPUT_MODE_FORMAT;
        ocrb_pkg::OFF_OUTPUT_DRIVE_ADJUST: drive_next = wr_data & ocrb_pkg::MASK_OUTPUT_DRIVE_ADJUST;
        ocrb_pkg::OFF_OUTPUT_CLOCK_PHASE: phase_next = wr_data & ocrb_pkg::MASK_OUTPUT_CLOCK_PHASE;
        ocrb_pkg::OFF_OUTPUT_CLOCK_DELAY: delay_next = wr_data & ocrb_pkg::MASK_OUTPUT_CLOCK_DELAY;
        default: ;
      endcase
    end
  end

  // Registered state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_reg <= ocrb_pkg::RST_OUTPUT_MODE_FORMAT;
      drive_reg <= ocrb_pkg::RST_OUTPUT_DRIVE_ADJUST;
      phase_reg <= ocrb_pkg::RST_OUTPUT_CLOCK_PHASE;
      delay_reg <= ocrb_pkg::RST_OUTPUT_CLOCK_DELAY;
    end else begin
      mode_reg <= mode_next;
      drive_reg <= drive_next;
      phase_reg <= phase_next;
      delay_reg <= delay_next;
    end
  end

  // Lowest code gives highest current, each step lower up to code 7, codes 8 and above at the code 7 level
  always_comb begin
    if (drive_reg[3]) begin
      drive_ua = ocrb_pkg::DRIVE_UA_MIN;
    end else begin
      drive_ua = ocrb_pkg::DRIVE_UA[drive_reg[2:0]];
    end
  end

  // Delay is (code+1) * 100 ps while enabled, zero otherwise
  always_comb begin
    if (delay_reg[ocrb_pkg::POS_DELAY_EN]) begin
      delay_ps = 12'((12'(delay_reg[4:0]) + 12'd1) * 12'(ocrb_pkg::DELAY_STEP_PS));
    end else begin
      delay_ps = 12'd0;
    end
  end

  property p_delay_step;
    @(posedge clock) disable iff (rst)
      delay_reg[7] |-> (delay_ps == 12'((12'(delay_reg[4:0]) + 12'd1) * 12'd100));
  endproperty
  a_delay_step: assert property (p_delay_step) else $error("delay step wrong");

  property p_delay_max;
    @(posedge clock) disable iff (rst)
      (delay_reg[7] && delay_reg[4:0] == 5'h1f) |-> (delay_ps == 12'd3200);
  endproperty
  a_delay_max: assert property (p_delay_max) else $error("max delay not 3.2 ns");

  property p_delay_zero_code;
    @(posedge clock) disable iff (rst)
      (delay_reg[7] && delay_reg[4:0] == 5'h00) |-> (delay_ps == 12'd100);
  endproperty
  a_delay_zero_code: assert property (p_delay_zero_code) else $error("zero code not 100 ps");

  property p_drive_monotonic;
    @(posedge clock) disable iff (rst)
      ($changed(drive_reg) && drive_reg > $past(drive_reg) && $past(drive_reg) < 8'h08)
        |-> (drive_ua <= $past(drive_ua));
  endproperty
  a_drive_monotonic: assert property (p_drive_monotonic) else $error("drive not decreasing");
endmodule

// [src/ocrb_top.sv]
/*
  Output configuration register bank: channel index, per-channel output settings, global reference select,
  read-only self-test signature. Assumes a serial-port front end hands over byte writes and reads on clock.
*/
// Overview of operation
// - Four-bit drive field; higher code means lower LVDS current up to code 7, codes 7 to 15 equal, code zero highest.
// - Drive field resets to the 3.5 mA code, register reads back 0x01.
// - Five-bit delay code; code zero adds 100 ps when delay enabled.
// - Each delay code step adds a further 100 ps.
// - All-ones delay code gives the largest delay, 3.2 ns.
// - Per-channel writes only change channels selected by the index register.
`timescale 1ns/100ps
module ocrb_top (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port from serial front end
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Self-test signature from the test engine
  input wire logic sig_load,
  input wire logic [15:0] sig_value,
  // Per-channel controls to the output stage
  output logic [3:0] out_disable,
  output logic [3:0] out_invert,
  output logic [7:0] out_format,
  output logic [15:0] drive_code,
  output logic [3:0] clk_invert,
  output logic [3:0] delay_enable,
  output logic [19:0] delay_code,
  output logic [47:0] drive_ua_all,
  output logic [47:0] delay_ps_all,
  // Global reference select
  output logic [4:0] ref_select
);
  localparam int N = ocrb_pkg::NUM_CH;

  logic [7:0] chan_index_reg, chan_index_next;
  logic [7:0] ref_reg, ref_next;
  logic [15:0] sig_reg, sig_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic [7:0] mode_r [N];
  logic [7:0] drive_r [N];
  logic [7:0] phase_r [N];
  logic [7:0] delay_r [N];
  logic [11:0] ua_w [N];
  logic [11:0] ps_w [N];
  logic [3:0] dis_next, inv_next, cinv_next, den_next;
  logic [7:0] fmt_next;
  logic [15:0] dcode_next;
  logic [19:0] dly_next;
  logic [47:0] ua_next, ps_next;

  // Lowest selected channel supplies local read-back
  function automatic int first_sel(input logic [7:0] idx);
    int r;
    r = 0;
    for (int i = N - 1; i >= 0; i--) begin
      if (idx[i]) begin
        r = i;
      end
    end
    return r;
  endfunction

  // Channel slices; each sees only writes gated by its index bit
  for (genvar g = 0; g < N; g++) begin : gen_ch
    ocrb_channel ocrb_channel_i (
      .clock(clock),
      .rst(rst),
      .wr_en(reg_wr & chan_index_reg[g]),
      .wr_addr(reg_addr),
      .wr_data(reg_wdata),
      .mode_reg(mode_r[g]),
      .drive_reg(drive_r[g]),
      .phase_reg(phase_r[g]),
      .delay_reg(delay_r[g]),
      .drive_ua(ua_w[g]),
      .delay_ps(ps_w[g])
    );
  end

  // Global registers and signature capture
  always_comb begin
    chan_index_next = chan_index_reg;
    ref_next = ref_reg;
    sig_next = sig_reg;
    if (reg_wr && reg_addr == ocrb_pkg::OFF_CHAN_INDEX) begin
      chan_index_next = reg_wdata & ocrb_pkg::MASK_CHAN_INDEX;
    end
    if (reg_wr && reg_addr == ocrb_pkg::OFF_REFERENCE_FULLSCALE_SELECT) begin
      ref_next = reg_wdata & ocrb_pkg::MASK_REFERENCE_FULLSCALE_SELECT;
    end
    // Host writes to signature offsets fall through: only the test engine loads it
    if (sig_load) begin
      sig_next = sig_value;
    end
  end

  // Read mux: one-cycle registered answer, unmapped reads return zero
  always_comb begin
    int c;
    c = first_sel(chan_index_reg);
    rdata_next = rdata_reg;
    rvalid_next = reg_rd;
    if (reg_rd) begin
      unique case (reg_addr)
        ocrb_pkg::OFF_CHAN_INDEX: rdata_next = chan_index_reg;
        ocrb_pkg::OFF_OUTPUT_MODE_FORMAT: rdata_next = mode_r[c];
        ocrb_pkg::OFF_OUTPUT_DRIVE_ADJUST: rdata_next = drive_r[c];
        ocrb_pkg::OFF_OUTPUT_CLOCK_PHASE: rdata_next = phase_r[c];
        ocrb_pkg::OFF_OUTPUT_CLOCK_DELAY: rdata_next = delay_r[c];
        ocrb_pkg::OFF_REFERENCE_FULLSCALE_SELECT: rdata_next = ref_reg;
        ocrb_pkg::OFF_SELFTEST_SIGNATURE_LOW: rdata_next = sig_reg[7:0];
        ocrb_pkg::OFF_SELFTEST_SIGNATURE_HIGH: rdata_next = sig_reg[15:8];
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Flatten channel fields onto output buses
  always_comb begin
    for (int i = 0; i < N; i++) begin
      dis_next[i] = mode_r[i][ocrb_pkg::POS_OUT_DISABLE];
      inv_next[i] = mode_r[i][ocrb_pkg::POS_OUT_INVERT];
      fmt_next[2*i +: 2] = mode_r[i][1:0];
      dcode_next[4*i +: 4] = drive_r[i][3:0];
      cinv_next[i] = phase_r[i][ocrb_pkg::POS_CLK_INVERT];
      den_next[i] = delay_r[i][ocrb_pkg::POS_DELAY_EN];
      dly_next[5*i +: 5] = delay_r[i][4:0];
      ua_next[12*i +: 12] = ua_w[i];
      ps_next[12*i +: 12] = ps_w[i];
    end
  end

  // Outputs registered so the output stage sees clean levels
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chan_index_reg <= ocrb_pkg::RST_CHAN_INDEX;
      ref_reg <= ocrb_pkg::RST_REFERENCE_FULLSCALE_SELECT;
      sig_reg <= 16'h0000;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      out_disable <= 4'h0;
      out_invert <= 4'h0;
      out_format <= 8'h00;
      drive_code <= 16'h1111;
      clk_invert <= 4'h0;
      delay_enable <= 4'h0;
      delay_code <= 20'h00000;
      drive_ua_all <= {4{12'd3500}};
      delay_ps_all <= 48'h0;
      ref_select <= 5'h00;
    end else begin
      chan_index_reg <= chan_index_next;
      ref_reg <= ref_next;
      sig_reg <= sig_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      out_disable <= dis_next;
      out_invert <= inv_next;
      out_format <= fmt_next;
      drive_code <= dcode_next;
      clk_invert <= cinv_next;
      delay_enable <= den_next;
      delay_code <= dly_next;
      drive_ua_all <= ua_next;
      delay_ps_all <= ps_next;
      ref_select <= ref_reg[4:0];
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;

  property p_unselected_hold;
    @(posedge clock) disable iff (rst)
      (reg_wr && !chan_index_reg[0]) |=> $stable(drive_r[0]) && $stable(delay_r[0]);
  endproperty
  a_unselected_hold: assert property (p_unselected_hold) else $error("unselected channel changed");

  property p_selected_write;
    @(posedge clock) disable iff (rst)
      (reg_wr && chan_index_reg[1] && reg_addr == 8'h15) |=> drive_r[1] == ($past(reg_wdata) & 8'h0f);
  endproperty
  a_selected_write: assert property (p_selected_write) else $error("selected write lost");

  property p_sig_ignore_write;
    @(posedge clock) disable iff (rst)
      (reg_wr && !sig_load && (reg_addr == 8'h24 || reg_addr == 8'h25)) |=> $stable(sig_reg);
  endproperty
  a_sig_ignore_write: assert property (p_sig_ignore_write) else $error("signature written by host");

  property p_sig_read;
    @(posedge clock) disable iff (rst)
      (reg_rd && reg_addr == 8'h25) |=> reg_rvalid && reg_rdata == $past(sig_reg[15:8]);
  endproperty
  a_sig_read: assert property (p_sig_read) else $error("signature high read wrong");

  property p_drive_reset;
    @(posedge clock) $fell(rst) |-> drive_r[0] == 8'h01 ##1 drive_code[3:0] == 4'h1;
  endproperty
  a_drive_reset: assert property (p_drive_reset) else $error("drive reset not 0x01");

  property p_delay_out;
    @(posedge clock) disable iff (rst)
      (delay_r[2][7] && delay_r[2][4:0] == 5'h01) |=> delay_ps_all[35:24] == 12'd200;
  endproperty
  a_delay_out: assert property (p_delay_out) else $error("code one not 200 ps");

  // Upper nibble of the drive register never holds written bits
  property p_drive_field_width;
    @(posedge clock) disable iff (rst)
      (reg_wr && chan_index_reg[0] && reg_addr == 8'h15) |=> drive_r[0][7:4] == 4'h0;
  endproperty
  a_drive_field_width: assert property (p_drive_field_width) else $error("drive field too wide");

  // With one channel selected, local read-back comes from that channel alone
  property p_selected_readback;
    @(posedge clock) disable iff (rst)
      (reg_rd && reg_addr == 8'h15 && chan_index_reg[3:0] == 4'h2) |=> reg_rdata == $past(drive_r[1]);
  endproperty
  a_selected_readback: assert property (p_selected_readback) else $error("readback not from selected channel");
endmodule

// [testbench/ocrb_host.sv]
/*
  Host model on the register port: one-cycle byte write and read strobes.
  Assumes the bench calls its tasks; every change lands on the falling clock edge.
*/
`timescale 1ns/100ps
module ocrb_host (
  // Clock
  input wire logic clock,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  // Idle port at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // Byte write; address and data flip on release so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // Byte read; waits a bounded time for the valid pulse
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    int i;
    @(negedge clock);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd = 1'b0;
    reg_addr = ~a;
    ok = 1'b0;
    d = 8'h00;
    for (i = 0; i < 4; i++) begin
      if (reg_rvalid === 1'b1) begin
        ok = 1'b1;
        d = reg_rdata;
        break;
      end
      @(negedge clock);
    end
  endtask
endmodule

// [testbench/ocrb_top_tb.sv]
/*
  Self-checking bench for the output configuration register bank.
  Assumes the host model drives the register port; bench drives reset and the signature load.
*/
`timescale 1ns/100ps
module ocrb_top_tb;
  logic clock, rst, reg_wr, reg_rd, reg_rvalid, sig_load;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, out_format;
  logic [15:0] sig_value, drive_code;
  logic [3:0] out_disable, out_invert, clk_invert, delay_enable;
  logic [19:0] delay_code;
  logic [47:0] drive_ua_all, delay_ps_all;
  logic [4:0] ref_select;
  int err_total;
  int n_compared;

  ocrb_top ocrb_top_i (.clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sig_load(sig_load),
    .sig_value(sig_value), .out_disable(out_disable), .out_invert(out_invert), .out_format(out_format),
    .drive_code(drive_code), .clk_invert(clk_invert), .delay_enable(delay_enable), .delay_code(delay_code),
    .drive_ua_all(drive_ua_all), .delay_ps_all(delay_ps_all), .ref_select(ref_select));
  ocrb_host ocrb_host_i (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // Free-running clock, 8 ns period
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Read and compare; a missing valid pulse ends the run
  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    ocrb_host_i.rd(a, d, ok);
    if (ok !== 1'b1) begin
      err_total++;
      report_and_stop();
    end
    check({40'h0, d}, {40'h0, exp});
  endtask

  // Output buses lag the register by one more edge
  task automatic settle();
    @(negedge clock);
  endtask

  task automatic t_reset();
    logic [7:0] zero_offs [6] = '{8'h14, 8'h16, 8'h17, 8'h18, 8'h24, 8'h25};
    rd_check(8'h05, 8'h0f);
    rd_check(8'h15, 8'h01);
    foreach (zero_offs[k]) rd_check(zero_offs[k], 8'h00);
    check({32'h0, drive_code}, {32'h0, 16'h1111});
    check(drive_ua_all, {4{12'd3500}});
    $display("t_reset done");
  endtask

  // Drive codes 0 to 8, highest current at code zero, step-wise lower up to code 7, code 8 same as 7
  task automatic t_drive();
    logic [11:0] ua [9] = '{12'd3720, 12'd3500, 12'd3300, 12'd2960, 12'd2820, 12'd2570, 12'd2270, 12'd2000, 12'd2000};
    for (int c = 0; c < 9; c++) begin
      ocrb_host_i.wr(8'h15, 8'(c));
      settle();
      check(drive_ua_all, {4{ua[c]}});
      check({32'h0, drive_code}, {32'h0, {4{4'(c)}}});
    end
    ocrb_host_i.wr(8'h15, 8'hf5);
    rd_check(8'h15, 8'h05);
    $display("t_drive done");
  endtask

  // Delay codes at both ends and in between, then disabled
  task automatic t_delay();
    logic [4:0] codes [4] = '{5'h00, 5'h01, 5'h02, 5'h1f};
    foreach (codes[k]) begin
      ocrb_host_i.wr(8'h17, {3'b100, codes[k]});
      settle();
      check(delay_ps_all, {4{12'((codes[k] + 1) * 100)}});
      check({28'h0, delay_code}, {28'h0, {4{codes[k]}}});
    end
    ocrb_host_i.wr(8'h17, 8'h1f);
    settle();
    check({44'h0, delay_enable}, 48'h0);
    check(delay_ps_all, 48'h0);
    rd_check(8'h17, 8'h1f);
    $display("t_delay done");
  endtask

  // Output disable, invert and format bits on every channel; open bits dropped
  task automatic t_mode();
    ocrb_host_i.wr(8'h14, 8'hff);
    settle();
    check({44'h0, out_disable}, {44'h0, 4'hf});
    check({44'h0, out_invert}, {44'h0, 4'hf});
    check({40'h0, out_format}, {40'h0, 8'hff});
    rd_check(8'h14, 8'h17);
    ocrb_host_i.wr(8'h14, 8'h01);
    settle();
    check({40'h0, out_format}, {40'h0, 8'h55});
    check({44'h0, out_disable}, 48'h0);
    check({44'h0, out_invert}, 48'h0);
    $display("t_mode done");
  endtask

  // Only the selected channel takes a local write
  task automatic t_chan();
    ocrb_host_i.wr(8'h05, 8'h02);
    ocrb_host_i.wr(8'h15, 8'h03);
    ocrb_host_i.wr(8'h16, 8'h80);
    settle();
    check({32'h0, drive_code}, {32'h0, 16'h5535});
    check({44'h0, clk_invert}, {44'h0, 4'h2});
    rd_check(8'h15, 8'h03);
    rd_check(8'h16, 8'h80);
    ocrb_host_i.wr(8'h05, 8'h0f);
    rd_check(8'h15, 8'h05);
    ocrb_host_i.wr(8'h18, 8'hff);
    settle();
    check({43'h0, ref_select}, {43'h0, 5'h1f});
    $display("t_chan done");
  endtask

  // Signature bytes read back, host writes dropped, unmapped read zero
  task automatic t_sig();
    @(negedge clock);
    sig_value = 16'ha55a;
    sig_load = 1'b1;
    @(negedge clock);
    sig_load = 1'b0;
    sig_value = 16'h5aa5;
    rd_check(8'h24, 8'h5a);
    rd_check(8'h25, 8'ha5);
    ocrb_host_i.wr(8'h24, 8'h00);
    ocrb_host_i.wr(8'h25, 8'h00);
    rd_check(8'h24, 8'h5a);
    rd_check(8'h25, 8'ha5);
    rd_check(8'h30, 8'h00);
    $display("t_sig done");
  endtask

  // Main sequence
  initial begin
    err_total = 0;
    n_compared = 0;
    rst = 1'b1;
    sig_load = 1'b0;
    sig_value = 16'h0000;
    repeat (10) @(negedge clock);
    rst = 1'b0;
    t_reset();
    t_drive();
    t_delay();
    t_mode();
    t_chan();
    t_sig();
    report_and_stop();
  end
endmodule
